//--- core/rcb_bank.sv
// APB register bank holding the reclose sequence records, controls and event masks.
`include "rcb_cfg.svh"
// Notes on behaviour
// - A sequence ended by final trip is stored as its code plus ten.
// - Five readable, writable sequence records hold codes 0 to 5 or 10 to 15; host writes take only 0 to 5 or 11 to 15.
// - Writing one to the indicator clear register clears the operation indicator.
// - Writing one to the combined clear clears the indicator and all records.
// - Shot disable zero allows reclosing shots; one suppresses every shot.
// - Writing one to module reset restarts timers and rewinds the shot pointer.
// - Three mask words gate events 1-11, 12-19, 20-27; only set bits report.
// - Mask words take 0 to 2047, 0 to 255 and 0 to 255.
module rcb_bank import rcb_pkg::*; (
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready, always high.
  output logic pslverr, // APB error on unmapped address.
  input wire logic seq_done, // Pulse: a reclose sequence finished.
  input wire logic [2:0] seq_code, // Normal code of that sequence, 0 to 5.
  input wire logic seq_final_trip, // Final trip operated in that sequence.
  input wire logic ind_set, // Pulse: new operation indicator value.
  input wire rcb_code_t ind_code, // Indicator value, 0 to 9.
  input wire rcb_events_t event_in, // Event pulses from the reclose logic.
  output rcb_events_t event_out, // Events that pass their mask.
  output logic shot_enable, // High while reclosing shots are allowed.
  output logic module_restart, // Pulse: restart timers, rewind shot pointer.
  output logic irq // Level interrupt.
);
  // APB phase decode; the slave never stalls, so pready is tied high.
  wire logic acc = psel & penable;
  wire logic wr_acc = acc & pwrite;
  wire logic rd_acc = acc & ~pwrite;
  wire logic hit_seq0 = (paddr == `RCB_OFF_SEQ0);
  wire logic hit_seq1 = (paddr == `RCB_OFF_SEQ1);
  wire logic hit_seq2 = (paddr == `RCB_OFF_SEQ2);
  wire logic hit_seq3 = (paddr == `RCB_OFF_SEQ3);
  wire logic hit_seq4 = (paddr == `RCB_OFF_SEQ4);
  wire logic hit_ind = (paddr == `RCB_OFF_IND);
  wire logic hit_ind_clr = (paddr == `RCB_OFF_IND_CLR);
  wire logic hit_all_clr = (paddr == `RCB_OFF_ALL_CLR);
  wire logic hit_shot = (paddr == `RCB_OFF_SHOT_DIS);
  wire logic hit_mrst = (paddr == `RCB_OFF_MOD_RST);
  wire logic hit_mlow = (paddr == `RCB_OFF_MASK_LOW);
  wire logic hit_mmid = (paddr == `RCB_OFF_MASK_MID);
  wire logic hit_mhigh = (paddr == `RCB_OFF_MASK_HIGH);
  wire logic hit_istat = (paddr == `RCB_OFF_IRQ_STAT);
  wire logic hit_imask = (paddr == `RCB_OFF_IRQ_MASK);
  wire logic mapped = hit_seq0 | hit_seq1 | hit_seq2 | hit_seq3 | hit_seq4 | hit_ind |
                      hit_ind_clr | hit_all_clr | hit_shot | hit_mrst | hit_mlow |
                      hit_mmid | hit_mhigh | hit_istat | hit_imask;

  // Sequence record writes only take legal codes; an illegal value is dropped whole.
  wire rcb_code_t wr_code = pwdata[3:0];
  wire logic code_legal = (pwdata[31:4] == 28'h0000000) &&
                          ((wr_code <= `RCB_SEQ_MAX_NORMAL) ||
                           (wr_code >= `RCB_SEQ_MIN_FINAL));
  wire logic [4:0] seq_wr = {5{wr_acc & code_legal}} &
                            {hit_seq4, hit_seq3, hit_seq2, hit_seq1, hit_seq0};

  // Reset registers fire only on a written one; a zero is a no-op.
  wire logic wr_one = (pwdata == 32'h00000001);
  wire logic ind_clr_cmd = wr_acc & hit_ind_clr & wr_one;
  wire logic all_clr_cmd = wr_acc & hit_all_clr & wr_one;
  wire logic mod_rst_cmd = wr_acc & hit_mrst & wr_one;

  // Final trip lifts the stored code by ten, e.g. 3 becomes 13.
  wire rcb_code_t rec_code = seq_final_trip ?
                             rcb_code_t'({1'b0, seq_code} + `RCB_FINAL_TRIP_ADD) :
                             rcb_code_t'({1'b0, seq_code});
  logic [19:0] hist;

  // Five-entry record history, cleared by the combined clear.
  rcb_seq_history u_hist (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(all_clr_cmd),
    .rec_valid(seq_done),
    .rec_code(rec_code),
    .wr_en(seq_wr),
    .wr_data(wr_code),
    .hist(hist)
  );

  // Operation indicator: clears win over a same-cycle new value, since the host
  // clear is an explicit acknowledge of what it has seen.
  rcb_code_t ind_reg;
  wire rcb_code_t ind_next = (ind_clr_cmd | all_clr_cmd) ? `RCB_SEQ_RESET :
                             (ind_set && ind_code <= `RCB_IND_MAX) ? ind_code : ind_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ind_reg <= `RCB_SEQ_RESET;
    end else begin
      ind_reg <= ind_next;
    end
  end

  // Shot disable and the self-clearing module reset pulse.
  logic shot_dis_reg;
  logic restart_reg;
  wire logic shot_dis_next = (wr_acc & hit_shot) ? pwdata[0] : shot_dis_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shot_dis_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      shot_dis_reg <= shot_dis_next;
      restart_reg <= mod_rst_cmd;
    end
  end
  assign shot_enable = ~shot_dis_reg;
  assign module_restart = restart_reg;

  // Event masks; writes outside the legal range are refused and the mask kept.
  logic [10:0] mask_low_reg;
  logic [7:0] mask_mid_reg;
  logic [7:0] mask_high_reg;
  wire logic low_ok = (pwdata[31:11] == 21'h000000);
  wire logic byte_ok = (pwdata[31:8] == 24'h000000);
  wire logic [10:0] mask_low_next = (wr_acc & hit_mlow & low_ok) ? pwdata[10:0] :
                                    mask_low_reg;
  wire logic [7:0] mask_mid_next = (wr_acc & hit_mmid & byte_ok) ? pwdata[7:0] :
                                   mask_mid_reg;
  wire logic [7:0] mask_high_next = (wr_acc & hit_mhigh & byte_ok) ? pwdata[7:0] :
                                    mask_high_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_low_reg <= `RCB_MASK_RESET;
      mask_mid_reg <= 8'h00;
      mask_high_reg <= 8'h00;
    end else begin
      mask_low_reg <= mask_low_next;
      mask_mid_reg <= mask_mid_next;
      mask_high_reg <= mask_high_next;
    end
  end

  logic event_any;
  // Event masking lives in its own module so the word layout sits in one place.
  rcb_event_gate u_gate (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .event_in(event_in),
    .mask_low(mask_low_reg),
    .mask_mid(mask_mid_reg),
    .mask_high(mask_high_reg),
    .event_out(event_out),
    .event_any(event_any)
  );

  // Interrupt status is sticky and write-one-to-clear; a new event beats the clear.
  rcb_irq_t irq_stat_reg;
  rcb_irq_t irq_mask_reg;
  rcb_irq_t irq_set;
  assign irq_set[`RCB_IRQ_SEQ_BIT] = seq_done;
  assign irq_set[`RCB_IRQ_EVT_BIT] = event_any;
  assign irq_set[`RCB_IRQ_IND_BIT] = ind_set;
  wire rcb_irq_t irq_clr = (wr_acc & hit_istat) ? pwdata[2:0] : 3'h0;
  wire rcb_irq_t irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);
  wire rcb_irq_t irq_mask_next = (wr_acc & hit_imask) ? pwdata[2:0] : irq_mask_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read mux; write-only and self-clearing registers read as zero.
  wire logic [31:0] rd_mux =
    hit_seq0 ? {28'h0000000, hist[3:0]} :
    hit_seq1 ? {28'h0000000, hist[7:4]} :
    hit_seq2 ? {28'h0000000, hist[11:8]} :
    hit_seq3 ? {28'h0000000, hist[15:12]} :
    hit_seq4 ? {28'h0000000, hist[19:16]} :
    hit_ind ? {28'h0000000, ind_reg} :
    hit_shot ? {31'h00000000, shot_dis_reg} :
    hit_mlow ? {21'h000000, mask_low_reg} :
    hit_mmid ? {24'h000000, mask_mid_reg} :
    hit_mhigh ? {24'h000000, mask_high_reg} :
    hit_istat ? {29'h00000000, irq_stat_reg} :
    hit_imask ? {29'h00000000, irq_mask_reg} : 32'h00000000;
  assign prdata = rd_acc ? rd_mux : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Checks next to the logic they guard.
  chk_final_trip_mark: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_done && !all_clr_cmd |=> hist[3:0] == $past(rec_code))
    else $error("final trip marking wrong");
  chk_final_plus_ten: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_done && seq_final_trip && seq_code != 3'h0 && !all_clr_cmd |=>
      hist[3:0] == rcb_code_t'({1'b0, $past(seq_code)} + 4'hA))
    else $error("final trip code not raised by ten");
  chk_seq_shift_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_done && !all_clr_cmd |=> hist[19:4] == $past(hist[15:0]))
    else $error("history did not shift");
  chk_seq_illegal_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_acc && hit_seq2 && !code_legal && !seq_done && !all_clr_cmd |=>
      $stable(hist[11:8]))
    else $error("illegal sequence code stored");
  chk_ind_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ind_clr_cmd |=> ind_reg == 4'h0)
    else $error("indicator not cleared");
  chk_all_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    all_clr_cmd |=> hist == 20'h00000 && ind_reg == 4'h0)
    else $error("combined clear incomplete");
  chk_shot_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_acc && hit_shot |=> shot_enable == !$past(pwdata[0]))
    else $error("shot enable does not follow write");
  chk_restart_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mod_rst_cmd ##1 !mod_rst_cmd |=> !module_restart)
    else $error("module restart longer than one cycle");
  chk_restart_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mod_rst_cmd |=> !module_restart)
    else $error("module restart without a written one");
  chk_event_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 event_out == ($past(event_in) & $past({mask_high_reg, mask_mid_reg, mask_low_reg})))
    else $error("event passed a cleared mask bit");
  chk_mask_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_acc && hit_mmid && !byte_ok |=> $stable(mask_mid_reg))
    else $error("out of range mask accepted");
  chk_irq_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_done |=> irq_stat_reg[0])
    else $error("sequence interrupt lost");

  cov_final_trip: cover property (@(posedge clk_sys) disable iff (!rst_n)
    seq_done && seq_final_trip);
  cov_all_clear: cover property (@(posedge clk_sys) disable iff (!rst_n)
    all_clr_cmd);
  cov_restart: cover property (@(posedge clk_sys) disable iff (!rst_n)
    module_restart);
  cov_event_out: cover property (@(posedge clk_sys) disable iff (!rst_n)
    |event_out && irq);
endmodule

//--- core/rcb_cfg.svh
// Offsets, field positions, reset values and codes of the reclose parameter bank.
`ifndef RCB_CFG_SVH
`define RCB_CFG_SVH
`define RCB_OFF_SEQ0 8'h00
`define RCB_OFF_SEQ1 8'h04
`define RCB_OFF_SEQ2 8'h08
`define RCB_OFF_SEQ3 8'h0C
`define RCB_OFF_SEQ4 8'h10
`define RCB_OFF_IND 8'h14
`define RCB_OFF_IND_CLR 8'h18
`define RCB_OFF_ALL_CLR 8'h1C
`define RCB_OFF_SHOT_DIS 8'h20
`define RCB_OFF_MOD_RST 8'h24
`define RCB_OFF_MASK_LOW 8'h28
`define RCB_OFF_MASK_MID 8'h2C
`define RCB_OFF_MASK_HIGH 8'h30
`define RCB_OFF_IRQ_STAT 8'h34
`define RCB_OFF_IRQ_MASK 8'h38
`define RCB_FINAL_TRIP_ADD 4'hA
`define RCB_SEQ_MAX_NORMAL 4'h5
`define RCB_SEQ_MIN_FINAL 4'hB
`define RCB_IND_MAX 4'h9
`define RCB_SEQ_RESET 4'h0
`define RCB_MASK_RESET 11'h000
`define RCB_IRQ_SEQ_BIT 0
`define RCB_IRQ_EVT_BIT 1
`define RCB_IRQ_IND_BIT 2
`endif

//--- core/rcb_event_gate.sv
// Passes reclose events through the three mask words and flags any reported one.
`include "rcb_cfg.svh"
module rcb_event_gate import rcb_pkg::*; (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire rcb_events_t event_in, // Event pulses, bit n-1 is event n.
  input wire logic [10:0] mask_low, // Mask for events 1 to 11.
  input wire logic [7:0] mask_mid, // Mask for events 12 to 19.
  input wire logic [7:0] mask_high, // Mask for events 20 to 27.
  output rcb_events_t event_out, // Reported events, one cycle late.
  output logic event_any // Pulse when any event was reported.
);
  wire rcb_events_t mask_all = {mask_high, mask_mid, mask_low};
  wire rcb_events_t passed = event_in & mask_all;
  rcb_events_t out_reg;
  logic any_reg;
  // Registered so the reported word is glitch free for the event consumer.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= '0;
      any_reg <= 1'b0;
    end else begin
      out_reg <= passed;
      any_reg <= |passed;
    end
  end
  assign event_out = out_reg;
  assign event_any = any_reg;
endmodule

//--- core/rcb_pkg.sv
// Types shared by the reclose parameter bank modules.
package rcb_pkg;
  typedef logic [3:0] rcb_code_t;
  typedef logic [7:0] rcb_addr_t;
  typedef logic [2:0] rcb_irq_t;
  typedef logic [26:0] rcb_events_t;
endpackage

//--- core/rcb_seq_history.sv
// Five-deep history of recorded reclose sequence codes, latest first.
`include "rcb_cfg.svh"
module rcb_seq_history import rcb_pkg::*; (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clear, // Clears all five entries.
  input wire logic rec_valid, // A new sequence code is pushed in.
  input wire rcb_code_t rec_code, // Code pushed in, already marked.
  input wire logic [4:0] wr_en, // Host write strobe per entry.
  input wire rcb_code_t wr_data, // Host write value.
  output logic [19:0] hist // Entry k in bits 4k+3..4k.
);
  // Each entry shifts down on a new record; clear beats record beats host write.
  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_ent
      rcb_code_t ent_reg;
      rcb_code_t ent_next;
      rcb_code_t shift_in;
      if (k == 0) begin : g_head
        assign shift_in = rec_code;
      end else begin : g_tail
        assign shift_in = hist[4*k-1 -: 4];
      end
      assign ent_next = clear ? `RCB_SEQ_RESET : rec_valid ? shift_in :
                        wr_en[k] ? wr_data : ent_reg;
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          ent_reg <= `RCB_SEQ_RESET;
        end else begin
          ent_reg <= ent_next;
        end
      end
      assign hist[4*k+3 -: 4] = ent_reg;
    end
  endgenerate
endmodule

//--- test/rcb_reclose_model.sv
// Stand-in for the reclose shot logic that feeds the parameter bank and obeys its controls.
module rcb_reclose_model import rcb_pkg::*; (
  input wire logic clk_sys, // System clock.
  input wire logic shot_enable, // Shots allowed while high.
  input wire logic module_restart, // Restart pulse from the bank.
  output logic seq_done, // Sequence finished pulse.
  output logic [2:0] seq_code, // Normal code of the finished sequence.
  output logic seq_final_trip, // Final trip operated in that sequence.
  output logic ind_set, // New indicator value pulse.
  output rcb_code_t ind_code, // Indicator value.
  output rcb_events_t event_in // Event pulses, bit n-1 is event n.
);
  timeunit 1ns;
  timeprecision 1ps;
  int restart_count = 0;
  int shot_ptr = 0;
  // Idle qualifiers carry inverted data so that a stale value is never mistaken for a new one.
  initial begin
    seq_done = 1'b0;
    seq_code = 3'h5;
    seq_final_trip = 1'b1;
    ind_set = 1'b0;
    ind_code = 4'hF;
    event_in = '0;
  end
  // Every restart pulse rewinds the shot pointer; a pulse held two cycles would count twice.
  always @(posedge clk_sys) begin
    if (module_restart === 1'b1) begin
      restart_count++;
      shot_ptr = 0;
    end
  end
  // Report one finished sequence with its normal code and final-trip flag.
  task automatic record(input logic [2:0] c, input logic ft);
    @(posedge clk_sys);
    seq_done <= 1'b1;
    seq_code <= c;
    seq_final_trip <= ft;
    @(posedge clk_sys);
    seq_done <= 1'b0;
    seq_code <= ~c;
    seq_final_trip <= ~ft;
  endtask
  // Present a new operation indicator value for one cycle.
  task automatic indicate(input rcb_code_t c);
    @(posedge clk_sys);
    ind_set <= 1'b1;
    ind_code <= c;
    @(posedge clk_sys);
    ind_set <= 1'b0;
    ind_code <= ~c;
  endtask
  // Pulse a set of events for one cycle.
  task automatic fire(input rcb_events_t ev);
    @(posedge clk_sys);
    event_in <= ev;
    @(posedge clk_sys);
    event_in <= '0;
  endtask
  // A shot is only taken while the bank allows shots.
  task automatic shot(output logic fired);
    @(posedge clk_sys);
    fired = (shot_enable === 1'b1);
    if (fired) shot_ptr++;
  endtask
endmodule

//--- test/reclose_parameter_bank_tb_top.sv
// Self-checking testbench of the reclose parameter bank over APB.
`include "rcb_cfg.svh"
`define RCB_CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module reclose_parameter_bank_tb_top import rcb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, seq_done, seq_final_trip, ind_set, shot_enable, module_restart, irq;
  logic [2:0] seq_code;
  rcb_code_t ind_code;
  rcb_events_t event_in, event_out;
  int errors = 0;
  int samples_checked = 0;
  logic [31:0] rdv;
  logic err, fired;
  int cnt;
  always #2 clk_sys = ~clk_sys;
  rcb_bank DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seq_done(seq_done), .seq_code(seq_code),
    .seq_final_trip(seq_final_trip), .ind_set(ind_set), .ind_code(ind_code),
    .event_in(event_in), .event_out(event_out), .shot_enable(shot_enable),
    .module_restart(module_restart), .irq(irq));
  rcb_reclose_model model (.clk_sys(clk_sys), .shot_enable(shot_enable),
    .module_restart(module_restart), .seq_done(seq_done), .seq_code(seq_code),
    .seq_final_trip(seq_final_trip), .ind_set(ind_set), .ind_code(ind_code),
    .event_in(event_in));
  // One APB transfer; the idle cycle in front keeps back-to-back calls from clashing.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    `RCB_CHK("write error", 1'b0, e)
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `RCB_CHK(nm, ex, r)
  endtask
  // Wait a couple of cycles so registered outputs have settled before looking.
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The whole sequence takes well under a thousand cycles; this only catches a hang.
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd_chk("seq reset", 8'(4 * i), 32'h0);
    `RCB_CHK("shot_enable reset", 1'b1, shot_enable)
    wr(`RCB_OFF_SEQ1, 32'h5);
    rd_chk("seq1 code 5", `RCB_OFF_SEQ1, 32'h5);
    wr(`RCB_OFF_SEQ2, 32'hB);
    rd_chk("seq2 code 11", `RCB_OFF_SEQ2, 32'hB);
    wr(`RCB_OFF_SEQ2, 32'h6);
    rd_chk("seq2 code 6 dropped", `RCB_OFF_SEQ2, 32'hB);
    model.record(3'h3, 1'b1);
    model.record(3'h2, 1'b0);
    rd_chk("seq0 plain", `RCB_OFF_SEQ0, 32'h2);
    rd_chk("seq1 final trip", `RCB_OFF_SEQ1, 32'hD);
    rd_chk("seq2 shifted", `RCB_OFF_SEQ2, 32'h0);
    rd_chk("seq3 shifted", `RCB_OFF_SEQ3, 32'h5);
    rd_chk("seq4 shifted", `RCB_OFF_SEQ4, 32'hB);
    model.indicate(4'h7);
    wr(`RCB_OFF_IND, 32'h3);
    rd_chk("indicator read only", `RCB_OFF_IND, 32'h7);
    rd_chk("status seq and ind", `RCB_OFF_IRQ_STAT, 32'h5);
    wr(`RCB_OFF_IND_CLR, 32'h0);
    rd_chk("indicator kept", `RCB_OFF_IND, 32'h7);
    wr(`RCB_OFF_IND_CLR, 32'h1);
    rd_chk("indicator cleared", `RCB_OFF_IND, 32'h0);
    rd_chk("records kept", `RCB_OFF_SEQ1, 32'hD);
    model.indicate(4'h9);
    wr(`RCB_OFF_ALL_CLR, 32'h1);
    rd_chk("indicator all clear", `RCB_OFF_IND, 32'h0);
    for (int i = 0; i < 5; i++) rd_chk("seq all clear", 8'(4 * i), 32'h0);
    wr(`RCB_OFF_SHOT_DIS, 32'h1);
    rd_chk("shot disable", `RCB_OFF_SHOT_DIS, 32'h1);
    model.shot(fired);
    `RCB_CHK("shot suppressed", 1'b0, fired)
    wr(`RCB_OFF_SHOT_DIS, 32'h0);
    settle();
    `RCB_CHK("shot_enable again", 1'b1, shot_enable)
    cnt = model.restart_count;
    wr(`RCB_OFF_MOD_RST, 32'h1);
    settle();
    `RCB_CHK("one restart", cnt + 1, model.restart_count)
    wr(`RCB_OFF_MOD_RST, 32'h0);
    settle();
    `RCB_CHK("no restart on zero", cnt + 1, model.restart_count)
    wr(`RCB_OFF_MASK_LOW, 32'h7FF);
    rd_chk("mask low max", `RCB_OFF_MASK_LOW, 32'h7FF);
    wr(`RCB_OFF_MASK_LOW, 32'h555);
    wr(`RCB_OFF_MASK_LOW, 32'h800);
    wr(`RCB_OFF_MASK_MID, 32'hA5);
    wr(`RCB_OFF_MASK_MID, 32'h100);
    wr(`RCB_OFF_MASK_HIGH, 32'hFF);
    wr(`RCB_OFF_MASK_HIGH, 32'h3C);
    rd_chk("mask low kept", `RCB_OFF_MASK_LOW, 32'h555);
    rd_chk("mask mid kept", `RCB_OFF_MASK_MID, 32'hA5);
    rd_chk("mask high", `RCB_OFF_MASK_HIGH, 32'h3C);
    wr(`RCB_OFF_IRQ_STAT, 32'h7);
    rd_chk("status cleared", `RCB_OFF_IRQ_STAT, 32'h0);
    wr(`RCB_OFF_IRQ_MASK, 32'h2);
    model.fire('1);
    #1;
    `RCB_CHK("event_out", {8'h3C, 8'hA5, 11'h555}, event_out)
    settle();
    `RCB_CHK("irq raised", 1'b1, irq)
    wr(`RCB_OFF_IRQ_MASK, 32'h0);
    #1;
    `RCB_CHK("irq masked", 1'b0, irq)
    wr(`RCB_OFF_IRQ_MASK, 32'h2);
    wr(`RCB_OFF_IRQ_STAT, 32'h2);
    #1;
    `RCB_CHK("irq cleared", 1'b0, irq)
    apb(1'b0, 8'h3C, 32'h0, rdv, err);
    `RCB_CHK("unmapped error", 1'b1, err)
    `RCB_CHK("unmapped data", 32'h0, rdv)
    end_of_test();
  end
endmodule
